/* File: rtl/rfa_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_top
  import rfa_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned NREG   = RFA_NUM_REG
) (
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               ahb_hsel_in,
  input  wire logic [ADDR_W-1:0]  ahb_haddr_in,
  input  wire logic [1:0]         ahb_htrans_in,
  input  wire logic               ahb_hwrite_in,
  input  wire logic [2:0]         ahb_hsize_in,
  input  wire logic [31:0]        ahb_hwdata_in,
  input  wire logic               ahb_hready_in,
  output logic      [31:0]        ahb_hrdata_out,
  output logic                    ahb_hreadyout_out,
  output logic                    ahb_hresp_out,
  input  wire logic [NREG*32-1:0] hw_set_in,
  input  wire logic [NREG*32-1:0] hw_val_in,
  output logic      [NREG*32-1:0] field_out,
  output logic      [NREG*32-1:0] trig_out
);

  if (NREG < 1 || NREG > RFA_NUM_REG) begin : g_chk_nreg
    $error("NREG outside the defined register map");
  end
  // wide arithmetic so that a full 32-bit address range is not refused
  if (ADDR_W < 3 || ADDR_W > 32 ||
      (64'(NREG) << RFA_WORD_SHIFT) > (64'(1) << ADDR_W))
  begin : g_chk_addr
    $error("ADDR_W cannot cover the register map");
  end

  rfa_state_t        state_q;
  logic              taken;
  logic              size_ok;
  logic [ADDR_W-1:0] addr_q;
  logic              write_q;
  logic              psel_q;
  logic              penable_q;
  logic [31:0]       pwdata_q;
  logic [31:0]       hrdata_q;
  logic              hready_q;
  logic              hresp_q;

  rfa_apb_if #(.ADDR_W(ADDR_W)) apb ();

  //////////////////////////////////////////////////////////////////////////
  // ahb address phase
  assign taken   = ahb_hsel_in & ahb_htrans_in[1] & ahb_hready_in;
  assign size_ok = (ahb_hsize_in <= RFA_SIZE_WORD);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_q  <= '0;
      write_q <= 1'b0;
    end else if (state_q == RFA_ST_IDLE && taken) begin
      // byte and halfword accesses become a word access
      addr_q  <= {ahb_haddr_in[ADDR_W-1:RFA_WORD_SHIFT],
                  {RFA_WORD_SHIFT{1'b0}}};
      write_q <= ahb_hwrite_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bridge sequencer, same clock on both sides
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= RFA_ST_IDLE;
    end else begin
      unique case (state_q)
        RFA_ST_IDLE: begin
          if (taken && size_ok) begin
            state_q <= RFA_ST_DATA;
          end else if (taken) begin
            state_q <= RFA_ST_ERR;
          end
        end
        RFA_ST_DATA:   state_q <= RFA_ST_SETUP;
        RFA_ST_SETUP:  state_q <= RFA_ST_ACCESS;
        RFA_ST_ACCESS: begin
          if (apb.pready) begin
            state_q <= apb.pslverr ? RFA_ST_ERR : RFA_ST_IDLE;
          end
        end
        RFA_ST_ERR:    state_q <= RFA_ST_IDLE;
        default:       state_q <= RFA_ST_IDLE;
      endcase
    end
  end

  // apb request signals
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      psel_q    <= 1'b0;
      penable_q <= 1'b0;
      pwdata_q  <= 32'h00000000;
    end else begin
      if (state_q == RFA_ST_DATA) begin
        psel_q   <= 1'b1;
        // full word lanes forwarded whatever the size
        pwdata_q <= write_q ? ahb_hwdata_in : 32'h00000000;
      end
      if (state_q == RFA_ST_SETUP) begin
        penable_q <= 1'b1;
      end
      if (state_q == RFA_ST_ACCESS && apb.pready) begin
        psel_q    <= 1'b0;
        penable_q <= 1'b0;
      end
    end
  end

  // ahb response
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
      hrdata_q <= 32'h00000000;
    end else begin
      unique case (state_q)
        RFA_ST_IDLE: begin
          hresp_q <= 1'b0;
          if (taken) begin
            hready_q <= 1'b0;
            hresp_q  <= ~size_ok;
          end
        end
        RFA_ST_ACCESS: begin
          if (apb.pready) begin
            hready_q <= ~apb.pslverr;
            hresp_q  <= apb.pslverr;
            hrdata_q <= (write_q || apb.pslverr) ? 32'h00000000
                                                 : apb.prdata;
          end
        end
        RFA_ST_ERR: begin
          hready_q <= 1'b1;
          hresp_q  <= 1'b1;
          // refused accesses return zero read data
          hrdata_q <= 32'h00000000;
        end
        default: begin
          hready_q <= 1'b0;
        end
      endcase
    end
  end

  assign apb.psel    = psel_q;
  assign apb.penable = penable_q;
  assign apb.pwrite  = write_q;
  assign apb.paddr   = addr_q;
  assign apb.pwdata  = pwdata_q;

  assign ahb_hrdata_out    = hrdata_q;
  assign ahb_hreadyout_out = hready_q;
  assign ahb_hresp_out     = hresp_q;

  //////////////////////////////////////////////////////////////////////////
  // field bank
  rfa_field_bank #(
    .ADDR_W (ADDR_W),
    .NREG   (NREG)
  ) u_bank (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .apb       (apb.bank),
    .hw_set_in (hw_set_in),
    .hw_val_in (hw_val_in),
    .field_out (field_out),
    .trig_out  (trig_out)
  );

endmodule : rfa_top
`default_nettype wire

/* File: shared/rfa_pkg.sv */
package rfa_pkg;

  // per-field access behaviour, one code per four-bit field
  typedef enum logic [3:0] {
    RFA_RW                  = 4'h0,
    RFA_RO                  = 4'h1,
    RFA_WO                  = 4'h2,
    RFA_CLEAR_ON_WRITE_ONE  = 4'h3,
    RFA_CLEAR_ON_WRITE_ZERO = 4'h4,
    RFA_CLEAR_ON_READ       = 4'h5,
    RFA_SET_ONLY            = 4'h6,
    RFA_WRITE_TRIGGER       = 4'h7,
    RFA_TOGGLE              = 4'h8
  } rfa_field_t;

  // bridge sequencer states
  typedef enum logic [4:0] {
    RFA_ST_IDLE   = 5'b00001,
    RFA_ST_DATA   = 5'b00010,
    RFA_ST_SETUP  = 5'b00100,
    RFA_ST_ACCESS = 5'b01000,
    RFA_ST_ERR    = 5'b10000
  } rfa_state_t;

  localparam int unsigned RFA_DATA_W     = 32;
  localparam int unsigned RFA_FIELD_W    = 4;
  localparam int unsigned RFA_NUM_REG    = 2;
  localparam int unsigned RFA_WORD_SHIFT = 2;

  // byte offsets of the registers
  localparam logic [11:0] RFA_REG0_OFS = 12'h000;
  localparam logic [11:0] RFA_REG1_OFS = 12'h004;

  // field type map, nibble n describes bits 4n+3..4n
  localparam logic [31:0] RFA_TYPE_MAP [RFA_NUM_REG] = '{
    32'h76543210,
    32'h01586308
  };

  // reset values
  localparam logic [31:0] RFA_RESET_VAL [RFA_NUM_REG] = '{
    32'h00000A0C,
    32'h00000000
  };

  // largest legal transfer size code (word)
  localparam logic [2:0] RFA_SIZE_WORD = 3'h2;

endpackage : rfa_pkg

/* File: shared/rfa_apb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rfa_apb_if #(
  parameter int unsigned ADDR_W = 12
);
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;

  modport bridge (
    output psel,
    output penable,
    output pwrite,
    output paddr,
    output pwdata,
    input  prdata,
    input  pready,
    input  pslverr
  );

  modport bank (
    input  psel,
    input  penable,
    input  pwrite,
    input  paddr,
    input  pwdata,
    output prdata,
    output pready,
    output pslverr
  );
endinterface : rfa_apb_if
`default_nettype wire

/* File: rtl/rfa_field_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_field_bank
  import rfa_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned NREG   = RFA_NUM_REG
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  rfa_apb_if.bank                   apb,
  input  wire logic [NREG*32-1:0]   hw_set_in,
  input  wire logic [NREG*32-1:0]   hw_val_in,
  output logic      [NREG*32-1:0]   field_out,
  output logic      [NREG*32-1:0]   trig_out
);

  localparam int unsigned IDX_W = ADDR_W - RFA_WORD_SHIFT;

  logic [IDX_W-1:0]   idx;
  logic               mapped;
  logic               acc;
  logic [NREG-1:0]    wr_sel;
  logic [NREG-1:0]    rd_sel;
  logic [NREG*32-1:0] field_q;
  logic [NREG*32-1:0] field_d;
  logic [NREG*32-1:0] rd_view;
  logic [NREG*32-1:0] trig_q;
  logic [NREG*32-1:0] trig_d;

  //////////////////////////////////////////////////////////////////////////
  // decode
  assign idx     = apb.paddr[ADDR_W-1:RFA_WORD_SHIFT];
  assign mapped  = (idx < IDX_W'(NREG));
  assign acc     = apb.psel & apb.penable;
  assign apb.pready  = 1'b1;
  assign apb.pslverr = acc & ~mapped;

  // next value of one bit by its access type
  function automatic logic next_bit(
    input rfa_field_t t,
    input logic       q,
    input logic       wr,
    input logic       rd,
    input logic       wd,
    input logic       hs,
    input logic       hv,
    input logic       rv
  );
    logic n;
    n = q;
    unique case (t)
      RFA_RW:                  n = wr ? wd : q;
      RFA_RO:                  n = hv;
      RFA_WO:                  n = wr ? wd : q;
      RFA_CLEAR_ON_WRITE_ONE:  n = hs | (q & ~(wr & wd));
      RFA_CLEAR_ON_WRITE_ZERO: n = hs | (q & ~(wr & ~wd));
      RFA_CLEAR_ON_READ:       n = hs | (q & ~rd);
      RFA_SET_ONLY:            n = q | (wr & wd);
      RFA_WRITE_TRIGGER:       n = hv;
      RFA_TOGGLE:              n = q ^ (wr & wd);
      default:                 n = rv;
    endcase
    return n;
  endfunction : next_bit

  //////////////////////////////////////////////////////////////////////////
  // per-register, per-bit field logic
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    assign wr_sel[r] = acc & apb.pwrite & mapped & (idx == IDX_W'(r));
    assign rd_sel[r] = acc & ~apb.pwrite & mapped & (idx == IDX_W'(r));
    for (genvar b = 0; b < 32; b++) begin : g_bit
      localparam rfa_field_t T =
        rfa_field_t'(RFA_TYPE_MAP[r][(b/RFA_FIELD_W)*RFA_FIELD_W +: 4]);
      localparam logic RV = RFA_RESET_VAL[r][b];
      // each bit follows its own type only
      assign field_d[r*32+b] = next_bit(T, field_q[r*32+b], wr_sel[r],
                                        rd_sel[r], apb.pwdata[b],
                                        hw_set_in[r*32+b],
                                        hw_val_in[r*32+b], RV);
      // write-only bits read back their reset value
      assign rd_view[r*32+b] = (T == RFA_WO) ? RV : field_q[r*32+b];
      // any write fires the event, data ignored
      assign trig_d[r*32+b]  = (T == RFA_WRITE_TRIGGER) & wr_sel[r];
    end
  end

  always_comb begin
    apb.prdata = 32'h00000000;
    for (int r = 0; r < NREG; r++) begin
      if (mapped && idx == IDX_W'(r)) begin
        apb.prdata = rd_view[r*32 +: 32];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // storage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int r = 0; r < NREG; r++) begin
        field_q[r*32 +: 32] <= RFA_RESET_VAL[r];
      end
    end else begin
      field_q <= field_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_q <= '0;
    end else begin
      trig_q <= trig_d;
    end
  end

  assign field_out = field_q;
  assign trig_out  = trig_q;

endmodule : rfa_field_bank
`default_nettype wire

/* File: dv/rfa_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_monitor
  import rfa_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned NREG   = RFA_NUM_REG
) (
  input wire logic               clk_in,
  input wire logic               rst_b_in,
  input wire logic               ahb_hsel_in,
  input wire logic [ADDR_W-1:0]  ahb_haddr_in,
  input wire logic [1:0]         ahb_htrans_in,
  input wire logic               ahb_hwrite_in,
  input wire logic [2:0]         ahb_hsize_in,
  input wire logic [31:0]        ahb_hwdata_in,
  input wire logic               ahb_hready_in,
  input wire logic [31:0]        ahb_hrdata_out,
  input wire logic               ahb_hreadyout_out,
  input wire logic               ahb_hresp_out,
  input wire logic [NREG*32-1:0] hw_set_in,
  input wire logic [NREG*32-1:0] hw_val_in,
  input wire logic [NREG*32-1:0] field_out,
  input wire logic [NREG*32-1:0] trig_out
);
  logic take;
  logic ok_req;
  logic wpend_q;
  logic in_map;
  assign in_map = ahb_haddr_in[ADDR_W-1:2] < NREG;
  assign take = ahb_hsel_in && ahb_htrans_in[1] && ahb_hready_in
                && ahb_hreadyout_out;
  assign ok_req = take && ahb_hsize_in <= RFA_SIZE_WORD;
  // write in flight, control bits may only move while set
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) wpend_q <= 1'b0;
    else if (take && ahb_hwrite_in) wpend_q <= 1'b1;
    else if (ahb_hreadyout_out) wpend_q <= 1'b0;
  end
  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  busy_drop_a: assert property (take |=> !ahb_hreadyout_out)
    else $error("ready stayed high after a request");
  ready_bound_a: assert property (
    ok_req && in_map |-> ##4 ahb_hreadyout_out)
    else $error("transfer did not finish in time");
  size_end_a: assert property (
    take && !ok_req |-> ##2 (ahb_hresp_out && ahb_hreadyout_out))
    else $error("size error response not ended");
  unmap_err_a: assert property (
    ok_req && !in_map |-> ##4 (ahb_hresp_out && !ahb_hreadyout_out)
    ##1 (ahb_hresp_out && ahb_hreadyout_out))
    else $error("unmapped access not refused");
  size_err_a: assert property (take && ahb_hsize_in > 3'h2
    |=> ahb_hresp_out && !ahb_hreadyout_out)
    else $error("oversize access not refused");
  ok_resp_a: assert property (ok_req && in_map
    |=> !ahb_hresp_out [*4])
    else $error("legal access answered with error");
  trig_bits_a: assert property ((trig_out & ~64'hF0000000) == 64'h0)
    else $error("trigger pulse outside trigger bits");
  trig_pulse_a: assert property (|trig_out |=> trig_out == '0)
    else $error("trigger pulse longer than one cycle");
  trig_fire_a: assert property (ok_req && ahb_hwrite_in
    && ahb_haddr_in[ADDR_W-1:2] == '0 |-> ##4 trig_out[31:28] == 4'hF)
    else $error("write did not fire trigger");
  ctrl_hold_a: assert property (!wpend_q |=>
    ((field_out ^ $past(field_out)) & 64'hF00FF0FF0F000F0F) == 64'h0)
    else $error("control bits moved without a write");
  ro_follow_a: assert property ($past(rst_b_in) |->
    {field_out[59:56], field_out[7:4]}
    == $past({hw_val_in[59:56], hw_val_in[7:4]}))
    else $error("read-only bits do not follow hardware");
endmodule : rfa_monitor
`default_nettype wire

/* File: dv/rfa_ahb_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module rfa_ahb_mst (
  input  wire logic  clk_in,
  input  wire logic  rdy_in,
  output logic       sel_out,
  output logic [11:0] addr_out,
  output logic [1:0] trans_out,
  output logic       write_out,
  output logic [2:0] size_out,
  output logic [31:0] wdata_out,
  output logic       busy_out
);
  initial begin
    sel_out = 1'b0;
    addr_out = 12'h0;
    trans_out = 2'h0;
    write_out = 1'b0;
    size_out = 3'h2;
    wdata_out = 32'h0;
    busy_out = 1'b0;
  end
  // one transfer: address phase, then data phase until ready
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [2:0] sz, input logic [31:0] d);
    int i;
    @(negedge clk_in);
    sel_out = 1'b1;
    trans_out = 2'h2;
    write_out = w;
    addr_out = a;
    size_out = sz;
    wdata_out = ~wdata_out;
    @(posedge clk_in);
    @(negedge clk_in);
    sel_out = 1'b0;
    trans_out = 2'h0;
    addr_out = ~a;
    write_out = ~w;
    wdata_out = d;
    busy_out = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk_in);
      if (rdy_in) break;
    end
    @(negedge clk_in);
    busy_out = 1'b0;
  endtask : xfer
endmodule : rfa_ahb_mst
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rfa_pkg::*;
;
  typedef struct {
    logic rd;
    logic rsp;
    logic [31:0] d;
    logic [63:0] t;
  } rfa_exp_t;
  rfa_exp_t    exp_q [$];
  rfa_exp_t    ex;
  logic        clk_in, rst_b_in, sel, wr, rdyo, rsp, busy;
  logic [11:0] addr;
  logic [1:0]  trans;
  logic [2:0]  size;
  logic [31:0] wdata, rdata, seed;
  logic [63:0] hws, hwv, fo, trg;
  logic [31:0] m [2];
  logic [31:0] pat [3] = '{32'hFFFFFFFF, 32'h00000000, 32'h5A5A5A5A};
  int          error_cnt, check_count;
  rfa_top u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .ahb_hsel_in(sel),
    .ahb_haddr_in(addr), .ahb_htrans_in(trans), .ahb_hwrite_in(wr),
    .ahb_hsize_in(size), .ahb_hwdata_in(wdata), .ahb_hready_in(rdyo),
    .ahb_hrdata_out(rdata), .ahb_hreadyout_out(rdyo), .ahb_hresp_out(rsp),
    .hw_set_in(hws), .hw_val_in(hwv), .field_out(fo), .trig_out(trg));
  rfa_ahb_mst u_mst (.clk_in(clk_in), .rdy_in(rdyo), .sel_out(sel),
    .addr_out(addr), .trans_out(trans), .write_out(wr), .size_out(size),
    .wdata_out(wdata), .busy_out(busy));
  always #10 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // software view (sw) or stored view of one register
  function automatic logic [31:0] view(input int r, input bit sw);
    logic [31:0] v;
    rfa_field_t  t;
    for (int n = 0; n < 8; n++) begin
      t = rfa_field_t'(RFA_TYPE_MAP[r][4*n+:4]);
      v[4*n+:4] = m[r][4*n+:4];
      if (t == RFA_RO || t == RFA_WRITE_TRIGGER) v[4*n+:4] = hwv[32*r+4*n+:4];
      if (t == RFA_WO && sw) v[4*n+:4] = RFA_RESET_VAL[r][4*n+:4];
    end
    return v;
  endfunction : view
  task automatic upd(input int r, input logic w, input logic rd,
                     input logic [31:0] d, input logic [31:0] s);
    rfa_field_t t;
    logic [3:0] q, x, h;
    for (int n = 0; n < 8; n++) begin
      t = rfa_field_t'(RFA_TYPE_MAP[r][4*n+:4]);
      q = m[r][4*n+:4];
      x = d[4*n+:4];
      h = s[4*n+:4];
      case (t)
        RFA_RW, RFA_WO:          q = w ? x : q;
        RFA_CLEAR_ON_WRITE_ONE:  q = (w ? q & ~x : q) | h;
        RFA_CLEAR_ON_WRITE_ZERO: q = (w ? q & x : q) | h;
        RFA_CLEAR_ON_READ:       q = (rd ? 4'h0 : q) | h;
        RFA_SET_ONLY:            q = w ? q | x : q;
        RFA_TOGGLE:              q = w ? q ^ x : q;
        default:                 q = q;
      endcase
      m[r][4*n+:4] = q;
    end
  endtask : upd
  task automatic op(input logic w, input logic [11:0] a,
                    input logic [2:0] sz, input logic [31:0] d);
    rfa_exp_t e;
    int       r;
    r = int'(a[11:2]);
    e.rd = !w;
    e.rsp = sz > RFA_SIZE_WORD || r >= int'(RFA_NUM_REG);
    e.d = e.rsp ? 32'h0 : view(r, 1'b1);
    e.t = (w && !e.rsp && r == 0) ? 64'hF0000000 : 64'h0;
    exp_q.push_back(e);
    if (!e.rsp) upd(r, w, !w, d, 32'h0);
    u_mst.xfer(w, a, sz, d);
    chk("field", {view(1, 1'b0), view(0, 1'b0)}, fo);
  endtask : op
  task automatic hwset(input logic [63:0] s);
    @(negedge clk_in);
    hws = s;
    @(negedge clk_in);
    hws = 64'h0;
    upd(0, 1'b0, 1'b0, 32'h0, s[31:0]);
    upd(1, 1'b0, 1'b0, 32'h0, s[63:32]);
  endtask : hwset
  task automatic finish_test();
    chk("pending", 64'h0, 64'(exp_q.size()));
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////
  // result watcher: oldest note against each completed transfer
  always @(posedge clk_in) begin
    if (busy && rdyo && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      chk("resp", 64'(ex.rsp), 64'(rsp));
      if (ex.rd) chk("rdata", 64'(ex.d), 64'(rdata));
      chk("trig", ex.t, trg);
    end
  end
  initial begin
    #(20 * 10000);
    error_cnt++;
    finish_test();
  end
  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    hws = 64'h0;
    hwv = 64'h0;
    seed = 32'h0000004C;
    m[0] = RFA_RESET_VAL[0];
    m[1] = RFA_RESET_VAL[1];
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_b_in = 1'b1;
    chk("reset", {view(1, 1'b0), view(0, 1'b0)}, fo);
    op(1'b0, 12'h000, 3'h2, 32'h0);
    op(1'b0, 12'h004, 3'h2, 32'h0);
    $display("test reset done");
    foreach (pat[i]) begin
      hwset({64{1'b1}});
      for (int r = 0; r < 2; r++) begin
        op(1'b1, 12'(4 * r), 3'h2, pat[i]);
        op(1'b0, 12'(4 * r), 3'h2, 32'h0);
        op(1'b0, 12'(4 * r), 3'h2, 32'h0);
      end
    end
    $display("test sweep done");
    for (int k = 0; k < 60; k++) begin
      seed = lfsr(seed);
      if (seed[3:0] == 4'h0) hwset({seed, ~seed});
      if (seed[5:4] == 2'h0) begin
        @(negedge clk_in);
        hwv = {~seed, seed};
      end
      op(seed[6], {9'h0, seed[7], seed[9:8]},
         {1'b0, seed[11:10] == 2'h3 ? 2'h2 : seed[11:10]},
         {seed[15:0], seed[31:16]});
    end
    $display("test random done");
    op(1'b1, 12'h000, 3'h3, 32'hFFFFFFFF);
    op(1'b0, 12'h004, 3'h4, 32'h0);
    op(1'b1, 12'h008, 3'h2, 32'hFFFFFFFF);
    op(1'b0, 12'h00C, 3'h0, 32'h0);
    $display("test error done");
    finish_test();
  end
endmodule : testbench
bind rfa_top rfa_monitor #(.ADDR_W(ADDR_W), .NREG(NREG)) u_mon (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .ahb_hsel_in(ahb_hsel_in),
  .ahb_haddr_in(ahb_haddr_in), .ahb_htrans_in(ahb_htrans_in),
  .ahb_hwrite_in(ahb_hwrite_in), .ahb_hsize_in(ahb_hsize_in),
  .ahb_hwdata_in(ahb_hwdata_in), .ahb_hready_in(ahb_hready_in),
  .ahb_hrdata_out(ahb_hrdata_out), .ahb_hreadyout_out(ahb_hreadyout_out),
  .ahb_hresp_out(ahb_hresp_out), .hw_set_in(hw_set_in),
  .hw_val_in(hw_val_in), .field_out(field_out), .trig_out(trig_out));
`default_nettype wire
